// [sram_cycle_timer.sv]
// down counter that times the phases of a memory access
module sram_cycle_timer #(
    parameter int CNT_W = 4
) (
    input wire logic i_mclk,               // system clock
    input wire logic i_sys_rst,            // synchronous reset, high
    input wire logic i_load,               // load a new count
    input wire logic [CNT_W-1:0] i_count,  // cycles minus one
    output logic o_zero                    // count has run out
);
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;

    always_comb begin
        count_nxt = count_r;
        if (i_load) begin
            count_nxt = i_count;
        end else if (count_r != '0) begin
            count_nxt = count_r - 1'b1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign o_zero = (count_r == '0);
endmodule

// [sram_host_ctrl.sv]
// host controller driving a 512K x 8 asynchronous static memory
module sram_host_ctrl #(
    parameter bit FAST_GRADE = 1'b0
) (
    input wire logic i_mclk,                                // 25 MHz clock
    input wire logic i_sys_rst,                             // sync reset
    input wire logic i_req_valid,                           // request
    input wire logic i_req_write,                           // 1 write
    input wire logic [sram_host_pkg::ADDR_W-1:0] i_req_addr, // address
    input wire logic [sram_host_pkg::DATA_W-1:0] i_req_wdata, // data
    output logic o_req_ready,                               // accept
    output logic o_rd_valid,                                // read pulse
    output logic [sram_host_pkg::DATA_W-1:0] o_rd_data,     // read byte
    output logic o_wr_done,                                 // write pulse
    input wire logic i_retain,                              // retention
    output logic o_retained,                                // in retention
    output logic [sram_host_pkg::ADDR_W-1:0] o_word_address, // pins
    output logic o_cs_n,                                    // chip select
    output logic o_oe_n,                                    // out enable
    output logic o_we_n,                                    // write strobe
    input wire logic [sram_host_pkg::DATA_W-1:0] i_byte_data_bus, // in
    output logic [sram_host_pkg::DATA_W-1:0] o_byte_data_bus, // out
    output logic o_byte_data_bus_oe_n                       // drive, low
);
    localparam int CW = sram_host_pkg::CNT_W;
    localparam int RD_CYC = (FAST_GRADE ? sram_host_pkg::RD_CYC_FAST
        : sram_host_pkg::RD_CYC_SLOW) + sram_host_pkg::SYNC_STAGES;
    localparam int WR_CYC = FAST_GRADE ? sram_host_pkg::WR_CYC_FAST
        : sram_host_pkg::WR_CYC_SLOW;
    localparam int RC_CYC = FAST_GRADE ? sram_host_pkg::RC_CYC_FAST
        : sram_host_pkg::RC_CYC_SLOW;
    localparam logic [CW-1:0] RD_LOAD = CW'(RD_CYC - 1);
    localparam logic [CW-1:0] WR_LOAD = CW'(WR_CYC - 1);
    localparam logic [CW-1:0] RC_LOAD = CW'(RC_CYC - 1);
    localparam logic [CW-1:0] TURN_LOAD = CW'(sram_host_pkg::TURN_CYC - 1);

    sram_host_pkg::host_state_t state_r;
    sram_host_pkg::host_state_t state_nxt;
    logic [sram_host_pkg::ADDR_W-1:0] addr_r;
    logic [sram_host_pkg::ADDR_W-1:0] addr_nxt;
    logic [sram_host_pkg::DATA_W-1:0] wdata_r;
    logic [sram_host_pkg::DATA_W-1:0] wdata_nxt;
    logic [sram_host_pkg::DATA_W-1:0] rdata_r;
    logic [sram_host_pkg::DATA_W-1:0] rdata_nxt;
    logic cs_n_r;
    logic cs_n_nxt;
    logic oe_n_r;
    logic oe_n_nxt;
    logic we_n_r;
    logic we_n_nxt;
    logic drive_n_r;
    logic drive_n_nxt;
    logic rd_valid_r;
    logic rd_valid_nxt;
    logic wr_done_r;
    logic wr_done_nxt;
    logic [sram_host_pkg::DATA_W-1:0] dq_meta_r;
    logic [sram_host_pkg::DATA_W-1:0] dq_sync_r;
    logic tmr_load;
    logic [CW-1:0] tmr_count;
    logic tmr_zero;

    sram_cycle_timer #(
        .CNT_W(CW)
    ) u_timer (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_load(tmr_load),
        .i_count(tmr_count),
        .o_zero(tmr_zero)
    );

    always_comb begin
        state_nxt = state_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        cs_n_nxt = cs_n_r;
        oe_n_nxt = oe_n_r;
        we_n_nxt = we_n_r;
        drive_n_nxt = drive_n_r;
        rd_valid_nxt = 1'b0;
        wr_done_nxt = 1'b0;
        tmr_load = 1'b0;
        tmr_count = '0;
        o_req_ready = 1'b0;
        case (state_r)
            sram_host_pkg::ST_IDLE: begin
                cs_n_nxt = 1'b1; // RQ23
                oe_n_nxt = 1'b1;
                we_n_nxt = 1'b1;
                drive_n_nxt = 1'b1; // RQ19
                if (i_retain) begin
                    state_nxt = sram_host_pkg::ST_RETAIN; // RQ21
                end else begin
                    o_req_ready = 1'b1;
                    if (i_req_valid) begin
                        // full 19-bit word address, one byte per access
                        addr_nxt = i_req_addr; // RQ1
                        wdata_nxt = i_req_wdata;
                        if (i_req_write) begin
                            // strobe first, select later keeps outputs off
                            we_n_nxt = 1'b0; // RQ6
                            drive_n_nxt = 1'b0; // RQ7
                            state_nxt = sram_host_pkg::ST_WR_SETUP;
                        end else begin
                            state_nxt = sram_host_pkg::ST_RD_SETUP;
                        end
                    end
                end
            end
            sram_host_pkg::ST_RD_SETUP: begin
                // address has stood a cycle before select falls
                cs_n_nxt = 1'b0; // RQ4
                oe_n_nxt = 1'b0;
                we_n_nxt = 1'b1; // RQ2
                tmr_load = 1'b1;
                tmr_count = RD_LOAD;
                state_nxt = sram_host_pkg::ST_RD_WAIT;
            end
            sram_host_pkg::ST_RD_WAIT: begin
                // wait covers access time plus the input synchroniser
                if (tmr_zero) begin
                    rdata_nxt = dq_sync_r; // RQ9 RQ10
                    rd_valid_nxt = 1'b1;
                    cs_n_nxt = 1'b1;
                    oe_n_nxt = 1'b1;
                    tmr_load = 1'b1;
                    tmr_count = TURN_LOAD;
                    state_nxt = sram_host_pkg::ST_RD_END;
                end
            end
            sram_host_pkg::ST_RD_END: begin
                // deselected turnaround so the memory releases the bus
                if (tmr_zero) begin
                    state_nxt = sram_host_pkg::ST_IDLE; // RQ13 RQ14
                end
            end
            sram_host_pkg::ST_WR_SETUP: begin
                cs_n_nxt = 1'b0; // RQ3
                tmr_load = 1'b1;
                tmr_count = WR_LOAD;
                state_nxt = sram_host_pkg::ST_WR_PULSE;
            end
            sram_host_pkg::ST_WR_PULSE: begin
                // select, address and data stand the whole pulse
                if (tmr_zero) begin
                    cs_n_nxt = 1'b1; // RQ16 RQ17 RQ18 RQ5
                    state_nxt = sram_host_pkg::ST_WR_END;
                end
            end
            sram_host_pkg::ST_WR_END: begin
                we_n_nxt = 1'b1;
                drive_n_nxt = 1'b1; // RQ19
                wr_done_nxt = 1'b1;
                state_nxt = sram_host_pkg::ST_IDLE;
            end
            sram_host_pkg::ST_RETAIN: begin
                cs_n_nxt = 1'b1; // RQ21
                if (!i_retain) begin
                    tmr_load = 1'b1;
                    tmr_count = RC_LOAD;
                    state_nxt = sram_host_pkg::ST_RECOVER;
                end
            end
            sram_host_pkg::ST_RECOVER: begin
                if (tmr_zero) begin
                    state_nxt = sram_host_pkg::ST_IDLE; // RQ22
                end
            end
            default: begin
                state_nxt = sram_host_pkg::ST_IDLE;
                cs_n_nxt = 1'b1;
                oe_n_nxt = 1'b1;
                we_n_nxt = 1'b1;
                drive_n_nxt = 1'b1;
            end
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_r <= sram_host_pkg::ST_IDLE;
            addr_r <= sram_host_pkg::ADDR_RST;
            wdata_r <= sram_host_pkg::DATA_RST;
            rdata_r <= sram_host_pkg::DATA_RST;
            cs_n_r <= 1'b1;
            oe_n_r <= 1'b1;
            we_n_r <= 1'b1;
            drive_n_r <= 1'b1;
            rd_valid_r <= 1'b0;
            wr_done_r <= 1'b0;
            dq_meta_r <= sram_host_pkg::DATA_RST;
            dq_sync_r <= sram_host_pkg::DATA_RST;
        end else begin
            state_r <= state_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            cs_n_r <= cs_n_nxt;
            oe_n_r <= oe_n_nxt;
            we_n_r <= we_n_nxt;
            drive_n_r <= drive_n_nxt;
            rd_valid_r <= rd_valid_nxt;
            wr_done_r <= wr_done_nxt;
            dq_meta_r <= i_byte_data_bus;
            dq_sync_r <= dq_meta_r;
        end
    end

    assign o_word_address = addr_r;
    assign o_cs_n = cs_n_r;
    assign o_oe_n = oe_n_r;
    assign o_we_n = we_n_r;
    assign o_byte_data_bus = wdata_r;
    assign o_byte_data_bus_oe_n = drive_n_r;
    assign o_rd_data = rdata_r;
    assign o_rd_valid = rd_valid_r;
    assign o_wr_done = wr_done_r;
    assign o_retained = (state_r == sram_host_pkg::ST_RETAIN);
endmodule

// [sram_host_ctrl_monitor.sv]
// pin protocol assertions for the memory host controller
module sram_host_ctrl_monitor (
    input wire logic i_mclk,                  // clock
    input wire logic i_sys_rst,               // reset
    input wire logic i_retain,                // retention ask
    input wire logic o_req_ready,             // accept
    input wire logic o_rd_valid,              // read pulse
    input wire logic o_wr_done,               // write pulse
    input wire logic o_retained,              // in retention
    input wire logic [18:0] o_word_address,   // address pins
    input wire logic o_cs_n,                  // select
    input wire logic o_oe_n,                  // output enable
    input wire logic o_we_n,                  // write strobe
    input wire logic [7:0] o_byte_data_bus,   // write data
    input wire logic o_byte_data_bus_oe_n     // drive enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);
    sequence s_wr_pulse;
        (!o_cs_n && !o_we_n && !o_byte_data_bus_oe_n && o_oe_n)[*2];
    endsequence
    sequence s_rd_wait;
        (!o_cs_n && !o_oe_n && o_we_n && $stable(o_word_address))[*4];
    endsequence
    a_wr_overlap: assert property (
        $fell(o_cs_n) && !o_we_n |-> s_wr_pulse ##1 o_cs_n)
        else $error("write pulse too short");
    a_wr_end: assert property (
        $rose(o_cs_n) && !o_we_n |-> $stable(o_word_address)
        && $stable(o_byte_data_bus) ##1 (o_wr_done && o_we_n))
        else $error("write end order wrong");
    a_rd_return: assert property (
        $fell(o_cs_n) && o_we_n |-> s_rd_wait ##1 (o_rd_valid && o_cs_n))
        else $error("read timing wrong");
    a_strobe_first: assert property (
        $fell(o_we_n) |-> o_cs_n && o_oe_n)
        else $error("strobe fell while selected");
    a_no_contend: assert property (
        !o_byte_data_bus_oe_n |-> o_oe_n && !o_we_n)
        else $error("bus driven outside write");
    a_read_strobe: assert property (
        !o_oe_n |-> o_we_n)
        else $error("strobe low in read");
    a_retain_off: assert property (
        o_retained |-> o_cs_n && !o_req_ready)
        else $error("selected in retention");
    a_recover_gap: assert property (
        $fell(o_retained) |-> (!o_req_ready && o_cs_n)[*2]
        ##1 (o_req_ready || i_retain))
        else $error("recovery gap wrong");
    a_ready_idle: assert property (
        o_req_ready |-> o_cs_n && o_we_n && !i_retain)
        else $error("ready while busy");
endmodule

// [sram_host_ctrl_tb.sv]
// self-checking bench for the memory host controller
module sram_host_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic wr;
        logic [18:0] a;
        logic [7:0] d;
    } row_t;
    logic i_mclk = 1'b0, i_sys_rst = 1'b1, i_retain = 1'b0;
    logic i_req_valid = 1'b0, i_req_write = 1'b0;
    logic [18:0] i_req_addr = 19'h00000, o_word_address;
    logic [7:0] i_req_wdata = 8'h00, o_rd_data, o_byte_data_bus;
    logic [7:0] i_byte_data_bus, mem_q, float_r = 8'h5A;
    logic o_req_ready, o_rd_valid, o_wr_done, o_retained, mem_drv;
    logic o_cs_n, o_oe_n, o_we_n, o_byte_data_bus_oe_n;
    int err_count = 0, compares = 0;
    row_t rows [8] = '{{1'b1, 19'h00000, 8'hA5}, {1'b1, 19'h7FFFF, 8'h3C},
        {1'b1, 19'h2AAAA, 8'h81}, {1'b0, 19'h00000, 8'hA5},
        {1'b0, 19'h7FFFF, 8'h3C}, {1'b0, 19'h2AAAA, 8'h81},
        {1'b1, 19'h00000, 8'h5A}, {1'b0, 19'h00000, 8'h5A}};
    always #20 i_mclk = ~i_mclk;
    // undriven bus changes every cycle
    always @(posedge i_mclk) float_r <= ~float_r;
    assign i_byte_data_bus = !o_byte_data_bus_oe_n ? o_byte_data_bus
        : mem_drv ? mem_q : float_r;
    sram_host_ctrl sram_host_ctrl_i (.i_mclk, .i_sys_rst, .i_req_valid,
        .i_req_write, .i_req_addr, .i_req_wdata, .o_req_ready, .o_rd_valid,
        .o_rd_data, .o_wr_done, .i_retain, .o_retained, .o_word_address,
        .o_cs_n, .o_oe_n, .o_we_n, .i_byte_data_bus, .o_byte_data_bus,
        .o_byte_data_bus_oe_n);
    sram_mem_model sram_mem_model_i (.i_word_address(o_word_address),
        .i_cs_n(o_cs_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
        .i_byte_data_bus(i_byte_data_bus), .o_q(mem_q), .o_drv(mem_drv));
    task automatic check(input logic ok, input string m);
        compares++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("Error at %0t: %s", $time, m);
        end
    endtask
    task automatic results;
        $display("checks %0d, mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_req(input row_t r);
        int k;
        int lat;
        logic done;
        // setup cycle and the timed phase, plus the closing cycle for writes
        lat = r.wr ? sram_host_pkg::WR_CYC_SLOW + 2
            : sram_host_pkg::RD_CYC_SLOW + sram_host_pkg::SYNC_STAGES + 1;
        @(negedge i_mclk);
        i_req_valid = 1'b1;
        i_req_write = r.wr;
        i_req_addr = r.a;
        i_req_wdata = r.d;
        k = 0;
        while (o_req_ready !== 1'b1 && k < 20) begin
            @(negedge i_mclk);
            k++;
        end
        check(k < 20, "request not taken");
        @(negedge i_mclk);
        i_req_valid = 1'b0;
        k = 0;
        done = 1'b0;
        while (!done && k < 20) begin
            done = r.wr ? o_wr_done === 1'b1 : o_rd_valid === 1'b1;
            if (!done) begin
                @(negedge i_mclk);
                k++;
            end
        end
        check(k == lat, "answer latency");
        if (!r.wr)
            check(o_rd_data === r.d, "read data");
    endtask
    initial begin
        #200000;
        err_count++;
        results();
    end
    initial begin
        repeat (12) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        check(o_cs_n === 1'b1 && o_req_ready === 1'b1, "reset state");
        foreach (rows[i]) do_req(rows[i]);
        // retention wins over a pending read
        @(negedge i_mclk);
        i_retain = 1'b1;
        i_req_valid = 1'b1;
        repeat (3) @(negedge i_mclk);
        check(o_retained === 1'b1 && o_cs_n === 1'b1, "no retention");
        check(o_req_ready === 1'b0, "ready in retention");
        i_retain = 1'b0;
        repeat (2) begin
            @(negedge i_mclk);
            check(o_req_ready === 1'b0, "early accept");
        end
        do_req(rows[7]);
        // reset in the middle of a read
        @(negedge i_mclk);
        i_req_valid = 1'b1;
        i_req_write = 1'b0;
        @(negedge i_mclk);
        i_req_valid = 1'b0;
        repeat (2) @(negedge i_mclk);
        i_sys_rst = 1'b1;
        @(negedge i_mclk);
        check(o_cs_n === 1'b1 && o_oe_n === 1'b1, "pins after reset");
        check(o_byte_data_bus_oe_n === 1'b1 && o_rd_valid === 1'b0, "rst");
        i_sys_rst = 1'b0;
        do_req(rows[7]);
        results();
    end
endmodule
bind sram_host_ctrl sram_host_ctrl_monitor sram_host_ctrl_monitor_i (
    .i_mclk, .i_sys_rst, .i_retain, .o_req_ready, .o_rd_valid, .o_wr_done,
    .o_retained, .o_word_address, .o_cs_n, .o_oe_n, .o_we_n,
    .o_byte_data_bus, .o_byte_data_bus_oe_n);

// [sram_host_pkg.sv]
// constants and types for the asynchronous static memory host controller
// Functional notes
// RQ1 - 512K byte locations, 19-bit address, 8-bit data
// RQ2 - write strobe stays high during reads
// RQ3 - write happens while select and strobe low
// RQ4 - address valid before select falls in reads
// RQ5 - strobe pulse exceeds turn-off plus data overlap
// RQ6 - select falling after strobe keeps outputs off
// RQ7 - host never drives while memory drives
// RQ8 - old data held 10 ns after address change
// RQ9 - data valid 45/55 ns after select
// RQ10 - data valid 25/30 ns after output enable
// RQ11 - outputs stay off 10 ns after select
// RQ12 - outputs stay off 5 ns after enable
// RQ13 - outputs off within 15/20 ns of deselect
// RQ14 - outputs off within 15/20 ns of disable
// RQ15 - outputs off within 15/20 ns of strobe
// RQ16 - address valid 40/50 ns before write end
// RQ17 - select low 40/50 ns before write end
// RQ18 - write data valid 20/25 ns before end
// RQ19 - write data hold after end is 0 ns
// RQ20 - outputs resume 5 ns after strobe ends
// RQ21 - deselect before retention, 0 ns minimum
// RQ22 - wait one read cycle after retention
// RQ23 - deselected memory ignores enables, stays off
package sram_host_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CNT_W = 4;
    localparam int SYNC_STAGES = 2;
    localparam int CLK_PERIOD_NS = 40;
    // speed grade figures, fast then slow; deselect turn-off for the slow grade only
    localparam int T_ACE_FAST_NS = 45;
    localparam int T_ACE_SLOW_NS = 55;
    localparam int T_OE_FAST_NS = 25;
    localparam int T_OE_SLOW_NS = 30;
    localparam int T_CW_FAST_NS = 40;
    localparam int T_CW_SLOW_NS = 50;
    localparam int T_WHZ_FAST_NS = 15;
    localparam int T_WHZ_SLOW_NS = 20;
    localparam int T_DW_FAST_NS = 20;
    localparam int T_DW_SLOW_NS = 25;
    localparam int T_RC_FAST_NS = 45;
    localparam int T_RC_SLOW_NS = 55;
    localparam int T_CHZ_SLOW_NS = 20;

    // least times round up to whole clock cycles
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction

    localparam int RD_CYC_FAST = ns_to_cyc(max2(T_ACE_FAST_NS, T_OE_FAST_NS));
    localparam int RD_CYC_SLOW = ns_to_cyc(max2(T_ACE_SLOW_NS, T_OE_SLOW_NS));
    localparam int WR_CYC_FAST = max2(ns_to_cyc(T_CW_FAST_NS),
        ns_to_cyc(T_WHZ_FAST_NS + T_DW_FAST_NS + 1));
    localparam int WR_CYC_SLOW = max2(ns_to_cyc(T_CW_SLOW_NS),
        ns_to_cyc(T_WHZ_SLOW_NS + T_DW_SLOW_NS + 1));
    localparam int RC_CYC_FAST = ns_to_cyc(T_RC_FAST_NS);
    localparam int RC_CYC_SLOW = ns_to_cyc(T_RC_SLOW_NS);
    // one deselected cycle must cover the bus release time
    localparam int TURN_CYC = ns_to_cyc(T_CHZ_SLOW_NS);

    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_SETUP,
        ST_RD_WAIT,
        ST_RD_END,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_END,
        ST_RETAIN,
        ST_RECOVER
    } host_state_t;
endpackage

// [sram_mem_model.sv]
// behavioural 512K x 8 static memory on the host pins
module sram_mem_model #(
    parameter int T_ACC = 55,
    parameter int T_OEA = 30
) (
    input wire logic [18:0] i_word_address,  // address
    input wire logic i_cs_n,                 // select
    input wire logic i_oe_n,                 // output enable
    input wire logic i_we_n,                 // write strobe
    input wire logic [7:0] i_byte_data_bus,  // resolved bus
    output logic [7:0] o_q,                  // read data
    output logic o_drv                       // driving the bus
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:524287];
    time t_cs = 0, t_oe = 0, t_we = 0, t_a = 0;
    logic [18:0] a_last = '0;
    logic sel;
    // evaluated every ns; garbage is shown until access time is met
    always begin
        #1;
        if (i_cs_n) t_cs = $time;
        if (i_oe_n) t_oe = $time;
        if (!i_we_n) t_we = $time;
        if (i_word_address !== a_last) t_a = $time;
        a_last = i_word_address;
        sel = !i_cs_n && !i_oe_n && i_we_n;
        o_drv = sel && $time - t_cs >= 10 && $time - t_oe >= 5
            && $time - t_we >= 5;
        // the previous byte stays 10 ns after an address change
        if ($time - t_a >= 10) begin
            if ($time - t_cs >= T_ACC && $time - t_oe >= T_OEA
                && $time - t_a >= T_ACC)
                o_q = mem[i_word_address];
            else
                o_q = ~mem[i_word_address];
        end
        if (!i_cs_n && !i_we_n)
            mem[i_word_address] = i_byte_data_bus;
    end
endmodule
